//--- logic/ets_defs.svh
// ets_defs.svh: offsets, field positions, reset values and timing counts of the
// two-wire eeprom slave front end.
// assumes a 50 MHz system clock; included by bare name after the package.
`ifndef ETS_DEFS_SVH
`define ETS_DEFS_SVH

// system clock period
`define ETS_CLK_PERIOD_NS 20
// input_glitch_filter_time, longest time so rounded down to whole cycles
`define ETS_FILT_TIME_NS 100
`define ETS_FILT_CYC (`ETS_FILT_TIME_NS / `ETS_CLK_PERIOD_NS)
// internal_program_time, longest time of the self-timed write
`define ETS_PROG_TIME_MS 10
`define ETS_PROG_CYC (`ETS_PROG_TIME_MS * 1000000 / `ETS_CLK_PERIOD_NS)

// select byte layout, msb sent first
`define ETS_SEL_CE_MSB 6
`define ETS_SEL_CE_LSB 4
`define ETS_SEL_ADDR_MSB 3
`define ETS_SEL_ADDR_LSB 1
`define ETS_SEL_RW_BIT 0
`define ETS_RW_READ 1'h1

// bit counter marks within one byte frame
`define ETS_LAST_BIT 4'h7
`define ETS_ACK_SLOT 4'h8
`define ETS_ACK_DONE 4'h9

// idle bus levels after reset
`define ETS_LINE_RST 1'h1

`endif

//--- logic/ets_front_end.sv
// ets_front_end: two-wire serial slave front end of a serial eeprom.
// assumes scl is the master's clock, sda is open drain with an outside pull-up,
// and a free-running clk_sys well above the bus rate.
//
// Functional notes
// - only the master starts transfers and clocks; device never drives scl.
// - sda falling while scl high is a start.
// - outside a write cycle, ignore the bus until a start is seen.
// - sda rising while scl high is a stop; it ends communication.
// - stop after a read command returns the device to standby.
// - stop after a write command starts the self-timed write, at most 10 ms.
// - the transmitter releases sda after eight data bits.
// - the receiver pulls sda low during the ninth clock to acknowledge.
// - incoming sda is captured on each rising scl edge.
// - select byte arrives msb first, seven code bits then direction bit.
// - select bits b6..b4 are compared with chip select pins e2..e0.
// - sda and scl pass a glitch filter of at most 100 ns; the bit capture here takes raw sda_in on raw scl edges.
// - eighth select bit high means read, low means write.
// - a matching select byte is acknowledged in the ninth bit time.
`timescale 1ns/1ps
`include "ets_defs.svh"

module ets_front_end #(
   parameter int PROG_CYC = `ETS_PROG_CYC
) (
   // system side
   input wire logic clk_sys,
   input wire logic reset,
   // two-wire link, scl also clocks the bit capture
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // chip select straps
   input wire logic [2:0] chip_select_pins,
   // toward the memory datapath
   output ets_pkg::ets_byte_t rx_byte,
   output logic rx_byte_valid,
   output logic selected,
   output logic sel_rw,
   output logic [2:0] sel_addr,
   output logic write_start,
   output logic write_busy,
   output logic standby
);
   import ets_pkg::*;

   function automatic logic sel_match(input ets_byte_t b, input logic [2:0] ce);
      sel_match = (b[`ETS_SEL_CE_MSB:`ETS_SEL_CE_LSB] == ce);
   endfunction : sel_match

   // link domain: one bit per rising scl, announced by a toggle
   logic link_bit_q, link_bit_d;
   logic link_tog_q, link_tog_d;

   always_comb begin
      link_bit_d = sda_in;
      link_tog_d = ~link_tog_q;
   end

   always_ff @(posedge scl or posedge reset) begin
      if (reset) begin
         link_bit_q <= 1'h0;
         link_tog_q <= 1'h0;
      end else begin
         link_bit_q <= link_bit_d;
         link_tog_q <= link_tog_d;
      end
   end

   // system domain: synchronise and filter both lines (index 0 scl, 1 sda)
   logic [1:0] pin_raw;
   logic [1:0] line_s;
   logic [1:0] line_f;
   assign pin_raw = {sda_in, scl};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_line
         logic meta_q, sync_q, filt_q, filt_d;
         logic [2:0] fcnt_q, fcnt_d;
         // a level must hold for the whole filter time before it is believed
         always_comb begin
            fcnt_d = 3'h0;
            filt_d = filt_q;
            if (sync_q != filt_q) begin
               if (fcnt_q == 3'(`ETS_FILT_CYC - 1)) begin
                  filt_d = sync_q;
               end else begin
                  fcnt_d = fcnt_q + 3'h1;
               end
            end
         end
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               meta_q <= `ETS_LINE_RST;
               sync_q <= `ETS_LINE_RST;
               filt_q <= `ETS_LINE_RST;
               fcnt_q <= 3'h0;
            end else begin
               meta_q <= pin_raw[gi];
               sync_q <= meta_q;
               filt_q <= filt_d;
               fcnt_q <= fcnt_d;
            end
         end
         assign line_s[gi] = sync_q;
         assign line_f[gi] = filt_q;
      end
   endgenerate

   // chip select straps through two flops, bit toggle through three (two to synchronise, one to find its edge)
   logic [2:0] ce_meta_q, ce_s_q;
   logic tog_meta_q, tog_s_q, tog_seen_q;
   logic [1:0] prev_q;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ce_meta_q <= 3'h0;
         ce_s_q <= 3'h0;
         tog_meta_q <= 1'h0;
         tog_s_q <= 1'h0;
         tog_seen_q <= 1'h0;
         prev_q <= {`ETS_LINE_RST, `ETS_LINE_RST};
      end else begin
         ce_meta_q <= chip_select_pins;
         ce_s_q <= ce_meta_q;
         tog_meta_q <= link_tog_q;
         tog_s_q <= tog_meta_q;
         tog_seen_q <= tog_s_q;
         prev_q <= line_f;
      end
   end

   logic start_ev, stop_ev, scl_fall, bit_ev;
   assign start_ev = line_f[0] & prev_q[0] & prev_q[1] & ~line_f[1];
   assign stop_ev = line_f[0] & prev_q[0] & ~prev_q[1] & line_f[1];
   assign scl_fall = prev_q[0] & ~line_f[0];
   // link_bit_q has been stable for two clk_sys cycles when the toggle lands;
   // a scl glitch shorter than the filter still yields a bit, a known limit
   assign bit_ev = tog_s_q ^ tog_seen_q;

   // byte framing, acknowledge and write cycle
   ets_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   ets_byte_t sh_q, sh_d;
   logic oe_q, oe_d;
   logic rw_q, rw_d;
   logic ok_q, ok_d;
   logic busy_q, busy_d;
   logic [18:0] pcnt_q, pcnt_d;
   logic rxv_q, rxv_d;
   logic ws_q, ws_d;
   logic [2:0] addr_q, addr_d;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      oe_d = oe_q;
      rw_d = rw_q;
      ok_d = ok_q;
      busy_d = busy_q;
      pcnt_d = pcnt_q;
      addr_d = addr_q;
      rxv_d = 1'h0;
      ws_d = 1'h0;
      if (busy_q) begin
         // the bus is ignored entirely until programming ends
         oe_d = 1'h0;
         st_d = ets_st_idle;
         if (pcnt_q == 19'h1) begin
            busy_d = 1'h0;
         end
         pcnt_d = pcnt_q - 19'h1;
      end else if (start_ev) begin
         st_d = ets_st_sel;
         cnt_d = 4'h0;
         oe_d = 1'h0;
      end else if (stop_ev) begin
         oe_d = 1'h0;
         st_d = ets_st_idle;
         if (st_q == ets_st_data && rw_q != `ETS_RW_READ) begin
            busy_d = 1'h1;
            pcnt_d = 19'(PROG_CYC);
            ws_d = 1'h1;
         end
      end else begin
         case (st_q)
            ets_st_sel, ets_st_data: begin
               if (bit_ev) begin
                  if (cnt_q <= `ETS_LAST_BIT) begin
                     sh_d = {sh_q[6:0], link_bit_q};
                     cnt_d = cnt_q + 4'h1;
                     if (cnt_q == `ETS_LAST_BIT) begin
                        if (st_q == ets_st_sel) begin
                           ok_d = sel_match(sh_d, ce_s_q);
                           rw_d = sh_d[`ETS_SEL_RW_BIT];
                           addr_d = sh_d[`ETS_SEL_ADDR_MSB:`ETS_SEL_ADDR_LSB];
                        end else if (rw_q != `ETS_RW_READ) begin
                           rxv_d = 1'h1;
                        end
                     end
                  end else if (cnt_q == `ETS_ACK_SLOT) begin
                     cnt_d = `ETS_ACK_DONE;
                     // a released ack from the master ends a read
                     if (st_q == ets_st_data && rw_q == `ETS_RW_READ && link_bit_q) begin
                        st_d = ets_st_idle;
                     end
                  end
               end else if (scl_fall) begin
                  if (cnt_q == `ETS_ACK_SLOT) begin
                     // read data is outside this block, so sda stays released then
                     oe_d = (st_q == ets_st_sel) ? ok_q : (rw_q != `ETS_RW_READ);
                  end else if (cnt_q == `ETS_ACK_DONE) begin
                     oe_d = 1'h0;
                     cnt_d = 4'h0;
                     if (st_q == ets_st_sel) begin
                        st_d = ok_q ? ets_st_data : ets_st_idle;
                     end
                  end
               end
            end
            ets_st_idle: begin
               oe_d = 1'h0;
            end
            default: begin
               st_d = ets_st_idle;
               oe_d = 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st_q <= ets_st_idle;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         oe_q <= 1'h0;
         rw_q <= 1'h0;
         ok_q <= 1'h0;
         busy_q <= 1'h0;
         pcnt_q <= 19'h0;
         rxv_q <= 1'h0;
         ws_q <= 1'h0;
         addr_q <= 3'h0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         oe_q <= oe_d;
         rw_q <= rw_d;
         ok_q <= ok_d;
         busy_q <= busy_d;
         pcnt_q <= pcnt_d;
         rxv_q <= rxv_d;
         ws_q <= ws_d;
         addr_q <= addr_d;
      end
   end

   // open drain: only ever pulls low, never drives scl
   assign sda_out = 1'h0;
   assign sda_oe = oe_q;
   assign rx_byte = sh_q;
   assign rx_byte_valid = rxv_q;
   assign selected = (st_q == ets_st_data);
   assign sel_rw = rw_q;
   assign sel_addr = addr_q;
   assign write_start = ws_q;
   assign write_busy = busy_q;
   assign standby = (st_q == ets_st_idle) & ~busy_q;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   logic quiet;
   assign quiet = ~busy_q & ~start_ev & ~stop_ev;

   property p_idle_quiet;
      st_q == ets_st_idle |-> !sda_oe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("sda pulled while idle");

   property p_start;
      start_ev && !busy_q |=> st_q == ets_st_sel && cnt_q == 4'h0 && !sda_oe;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_busy_ignore;
      busy_q |=> st_q == ets_st_idle && !sda_oe;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("bus served while busy");

   property p_stop;
      stop_ev && !busy_q && !(st_q == ets_st_data && !rw_q) |=> standby && !sda_oe;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not reach standby");

   property p_write_cycle;
      stop_ev && !busy_q && st_q == ets_st_data && !rw_q
         |=> write_start && busy_q && pcnt_q == 19'(PROG_CYC) ##1 !write_start;
   endproperty
   a_write_cycle: assert property (p_write_cycle) else $error("write cycle not started");

   property p_write_end;
      busy_q && pcnt_q == 19'h1 |=> !busy_q && standby;
   endproperty
   a_write_end: assert property (p_write_end) else $error("write cycle did not end");

   property p_release;
      st_q != ets_st_idle && cnt_q <= `ETS_LAST_BIT && cnt_q != 4'h0 |-> !sda_oe;
   endproperty
   a_release: assert property (p_release) else $error("sda held during data bits");

   property p_ack;
      quiet && scl_fall && cnt_q == `ETS_ACK_SLOT && st_q == ets_st_sel && ok_q
         |=> sda_oe;
   endproperty
   a_ack: assert property (p_ack) else $error("matching select not acked");

   property p_nack;
      quiet && scl_fall && cnt_q == `ETS_ACK_SLOT && st_q == ets_st_sel && !ok_q
         |=> !sda_oe ##1 (!sda_oe);
   endproperty
   a_nack: assert property (p_nack) else $error("mismatch was acked");

   property p_shift;
      quiet && bit_ev && st_q != ets_st_idle && cnt_q <= `ETS_LAST_BIT
         |=> sh_q[0] == $past(link_bit_q) && cnt_q == $past(cnt_q) + 4'h1;
   endproperty
   a_shift: assert property (p_shift) else $error("bit not shifted in");

   property p_match;
      st_q == ets_st_sel && cnt_q == `ETS_ACK_SLOT
         |-> ok_q == sel_match(sh_q, ce_s_q) && rw_q == sh_q[`ETS_SEL_RW_BIT];
   endproperty
   a_match: assert property (p_match) else $error("select decode wrong");

   property p_filter;
      $changed(line_f[0]) |-> $past(line_s[0], 1) == line_f[0]
         && $past(line_s[0], 5) == line_f[0];
   endproperty
   a_filter: assert property (p_filter) else $error("scl filter passed a glitch");

endmodule : ets_front_end

//--- logic/ets_pkg.sv
// ets_pkg: types of the two-wire eeprom slave front end.
// assumes nothing beyond a SystemVerilog compiler.
package ets_pkg;

   typedef enum logic [1:0] {
      ets_st_idle,
      ets_st_sel,
      ets_st_data
   } ets_state_t;

   typedef logic [7:0] ets_byte_t;

endpackage : ets_pkg

//--- sim/ets_front_end_tb.sv
// ets_front_end_tb: self-checking bench of the two-wire slave front end.
// assumes ets_master as bus partner and a shortened self-timed write.
`timescale 1ns/1ps

module ets_front_end_tb;
   import ets_pkg::*;
   localparam int PROG = 5000;
   localparam int LIMIT = 90000;
   localparam logic [2:0] PINS = 3'h5;
   logic clk_sys, reset, sda_in, sda_out, sda_oe, scl, sda_drv, ack;
   logic rx_byte_valid, selected, sel_rw, write_start, write_busy, standby;
   logic [2:0] pins, sel_addr;
   ets_byte_t rx_byte;
   logic [7:0] last_byte;
   int err_count = 0, comparisons = 0, cyc = 0, n_valid = 0, n_ws = 0, busy_cnt = 0;

   // open drain with pull-up: either party pulling low wins
   assign sda_in = sda_drv & ~(sda_oe & ~sda_out);

   ets_front_end #(.PROG_CYC(PROG)) u_dut (.clk_sys(clk_sys), .reset(reset), .scl(scl),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pins(pins),
      .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .selected(selected),
      .sel_rw(sel_rw), .sel_addr(sel_addr), .write_start(write_start),
      .write_busy(write_busy), .standby(standby));
   ets_master #(.HALF(200)) u_mst (.clk_sys(clk_sys), .sda_w(sda_in), .scl(scl),
      .sda_drv(sda_drv));

   initial begin
      clk_sys = 1'h0;
      forever #10 clk_sys = ~clk_sys;
   end

   // pulses are caught on the falling edge, clear of the edge that launches them
   always @(negedge clk_sys) begin
      cyc++;
      if (rx_byte_valid === 1'h1) begin
         n_valid++;
         last_byte = rx_byte;
      end
      if (write_start === 1'h1) n_ws++;
      if (write_busy === 1'h1) busy_cnt++;
      if (cyc == LIMIT) begin
         err_count++;
         end_of_test();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic end_of_test();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test

   task automatic wait_idle();
      for (int k = 0; k < PROG && write_busy !== 1'h0; k++) u_mst.wt(1);
      u_mst.wt(4);
   endtask : wait_idle

   task automatic s_write();
      u_mst.start_c();
      u_mst.byte_x({1'h1, PINS, 3'h6, 1'h0}, ack);
      u_mst.wt(20);
      chk("select ack", 1, ack);
      chk("selected", 1, selected);
      chk("sda released", 0, sda_oe);
      chk("sel_addr", 3'h6, sel_addr);
      chk("sel_rw", 0, sel_rw);
      u_mst.byte_x(8'hA5, ack);
      u_mst.wt(20);
      chk("data ack", 1, ack);
      chk("valid count", 1, n_valid);
      chk("rx_byte", 8'hA5, last_byte);
      u_mst.stop_c();
      chk("write_start", 1, n_ws);
      chk("write_busy", 1, write_busy);
      chk("standby busy", 0, standby);
   endtask : s_write

   task automatic s_busy();
      u_mst.start_c();
      u_mst.byte_x({1'h1, PINS, 3'h6, 1'h0}, ack);
      chk("busy ack", 0, ack);
      u_mst.stop_c();
      wait_idle();
      chk("busy length", PROG, busy_cnt);
      chk("standby after", 1, standby);
   endtask : s_busy

   task automatic s_read();
      u_mst.start_c();
      u_mst.byte_x({1'h1, PINS, 3'h1, 1'h1}, ack);
      u_mst.wt(20);
      chk("read ack", 1, ack);
      chk("sel_rw read", 1, sel_rw);
      u_mst.byte_x(8'hFF, ack);
      u_mst.wt(20);
      chk("read data not acked", 0, ack);
      chk("nack ends read", 0, selected);
      chk("no read valid", 1, n_valid);
      u_mst.stop_c();
      chk("standby read", 1, standby);
      chk("no write", 1, n_ws);
   endtask : s_read

   task automatic s_nomatch();
      for (int i = 0; i < 3; i++) begin
         u_mst.start_c();
         u_mst.byte_x({1'h1, PINS ^ (3'h1 << i), 3'h0, 1'h0}, ack);
         u_mst.wt(20);
         chk("mismatch ack", 0, ack);
         chk("not selected", 0, selected);
      end
      u_mst.stop_c();
      chk("no write start", 1, n_ws);
   endtask : s_nomatch

   task automatic s_restart();
      u_mst.start_c();
      for (int i = 0; i < 4; i++) u_mst.bit_x(i[0], ack);
      u_mst.start_c();
      u_mst.byte_x({1'h1, PINS, 3'h2, 1'h0}, ack);
      u_mst.wt(20);
      chk("restart ack", 1, ack);
      chk("restart addr", 3'h2, sel_addr);
      u_mst.stop_c();
      wait_idle();
      chk("second write", 2, n_ws);
      chk("busy total", 2 * PROG, busy_cnt);
   endtask : s_restart

   // straps move only while the bus is idle, so a select never sees them change
   task automatic s_pins();
      logic [2:0] v;
      for (int i = 0; i < 2; i++) begin
         v = i[0] ? 3'h7 : 3'h0;
         pins = v;
         u_mst.wt(4);
         u_mst.start_c();
         u_mst.byte_x({1'h1, v, 3'h4, 1'h1}, ack);
         u_mst.wt(20);
         chk("strap ack", 1, ack);
         chk("strap addr", 3'h4, sel_addr);
         u_mst.stop_c();
      end
   endtask : s_pins

   task automatic s_reset();
      u_mst.start_c();
      u_mst.byte_x({1'h1, pins, 3'h3, 1'h0}, ack);
      chk("write select ack", 1, ack);
      u_mst.stop_c();
      chk("busy before reset", 1, write_busy);
      reset = 1'h1;
      u_mst.wt(3);
      reset = 1'h0;
      u_mst.wt(2);
      chk("busy cleared", 0, write_busy);
      chk("standby cleared", 1, standby);
      chk("oe cleared", 0, sda_oe);
      u_mst.start_c();
      u_mst.byte_x({1'h1, pins, 3'h3, 1'h1}, ack);
      u_mst.wt(20);
      chk("ack after reset", 1, ack);
      u_mst.stop_c();
      chk("write starts", 3, n_ws);
      chk("read stop standby", 1, standby);
   endtask : s_reset

   initial begin
      reset = 1'h1;
      pins = PINS;
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      reset = 1'h0;
      u_mst.wt(10);
      chk("standby reset", 1, standby);
      chk("sda_out", 0, sda_out);
      s_write();
      s_busy();
      s_read();
      s_nomatch();
      s_restart();
      s_pins();
      s_reset();
      end_of_test();
   end
endmodule : ets_front_end_tb

//--- sim/ets_master.sv
// ets_master: behavioural two-wire bus master for the front end bench.
// assumes sda is resolved outside with a pull-up; times are counted in clk_sys cycles.
`timescale 1ns/1ps

module ets_master #(
   parameter int HALF = 200
) (
   // timing reference
   input wire logic clk_sys,
   // bus
   input wire logic sda_w,
   output logic scl,
   output logic sda_drv
);
   // scl parks high between frames; it runs only inside tasks
   initial begin
      scl = 1'h1;
      sda_drv = 1'h1;
   end

   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wt

   task automatic start_c();
      wt(HALF / 2);
      sda_drv = 1'h1;
      wt(HALF / 2);
      scl = 1'h1;
      wt(HALF);
      sda_drv = 1'h0;
      wt(HALF);
      scl = 1'h0;
   endtask : start_c

   task automatic stop_c();
      wt(HALF / 2);
      sda_drv = 1'h0;
      wt(HALF / 2);
      scl = 1'h1;
      wt(HALF);
      sda_drv = 1'h1;
      wt(HALF);
   endtask : stop_c

   // sda moves mid-low only, so filtered lines never fake a start or stop
   task automatic bit_x(input logic b, output logic s);
      wt(HALF / 2);
      sda_drv = b;
      wt(HALF / 2);
      scl = 1'h1;
      wt(HALF);
      s = sda_w;
      scl = 1'h0;
   endtask : bit_x

   task automatic byte_x(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(d[i], s);
      bit_x(1'h1, s);
      ack = ~s;
   endtask : byte_x
endmodule : ets_master
